// ### hw/cds_consts.svh
// Constants of the caller display receiver: register map, field positions,
// reset values, mode-pin codes and timing figures.
// Assumes inclusion by the package and design files under one include path.
`ifndef CDS_CONSTS_SVH
`define CDS_CONSTS_SVH

// ****************************************************************
// Register byte offsets on the AHB-Lite slave
// ****************************************************************
`define CDS_OFF_STATUS    5'h00
`define CDS_OFF_MASK      5'h04
`define CDS_OFF_STATE     5'h08
`define CDS_OFF_PRES_TIME 5'h0C
`define CDS_OFF_ABS_TIME  5'h10
`define CDS_ADDR_HI_LSB   5

// ****************************************************************
// Field layout
// ****************************************************************
`define CDS_EV_TONE_RISE  0
`define CDS_EV_TONE_FALL  1
`define CDS_EV_CARR_GAIN  2
`define CDS_EV_CARR_LOSS  3
`define CDS_EV_MODE_CHG   4
`define CDS_EV_W          5
`define CDS_TIME_W        8

// ****************************************************************
// Reset values (interval figures in ms)
// ****************************************************************
`define CDS_MASK_RST      5'h00
`define CDS_GP_RST        8'h0A
`define CDS_DP_RST        8'h0A
`define CDS_GA_RST        8'h0F
`define CDS_DA_RST        8'h0A

// ****************************************************************
// Mode-select pin codes
// ****************************************************************
`define CDS_CODE_PDN      3'h0
`define CDS_CODE_ALERT    3'h1
`define CDS_CODE_FSK_BYTE 3'h3
`define CDS_CODE_FSK_BIT  3'h2

// ****************************************************************
// Timing: one interval unit is 1 ms at a 25 ns clock
// ****************************************************************
`define CDS_UNIT_NS       1000000
`define CDS_CLK_NS        25
`define CDS_UNIT_CYCLES   (`CDS_UNIT_NS / `CDS_CLK_NS)

`endif

// ### hw/cds_pkg.sv
// Types shared by the caller display receiver modules.
// Assumes cds_consts.svh is on the include path.
`include "cds_consts.svh"

package cds_pkg;

  // Mode decoded from the three mode-select pins
  typedef enum logic [2:0] {
    CDS_MODE_PDN      = `CDS_CODE_PDN,
    CDS_MODE_ALERT    = `CDS_CODE_ALERT,
    CDS_MODE_FSK_BYTE = `CDS_CODE_FSK_BYTE,
    CDS_MODE_FSK_BIT  = `CDS_CODE_FSK_BIT
  } cds_mode_e;

  // Tone qualifier state
  typedef enum logic [1:0] {
    CDS_TONE_OFF = 2'h0,
    CDS_TONE_ON  = 2'h1
  } cds_tone_e;

  typedef logic [`CDS_TIME_W-1:0] cds_time_t;

endpackage : cds_pkg

// ### hw/cds_tmr_if.sv
// Link between the register block and the tone qualifier.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface cds_tmr_if;
  import cds_pkg::*;
  logic      tone_in;   // Raw tone comparator level
  logic      enable;    // Alert detection selected
  cds_time_t gp;        // Present guard, ms
  cds_time_t dp;        // Present detect, ms
  cds_time_t ga;        // Absent guard, ms
  cds_time_t da;        // Absent detect, ms
  logic      detect;    // Qualified tone

  modport ctl (output tone_in, output enable, output gp, output dp, output ga, output da, input detect);
  modport tmr (input tone_in, input enable, input gp, input dp, input ga, input da, output detect);
endinterface : cds_tmr_if

// ### hw/cds_tone_timer.sv
// Tone qualifier: turns the raw tone level into the tone-detect level using
// guard plus detect intervals counted in 1 ms units.
// Assumes the tone level is synchronous to hclk.
`timescale 1ns/1ps
`include "cds_consts.svh"

module cds_tone_timer
  import cds_pkg::*;
#(
  parameter int UNIT_CYCLES = `CDS_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Link to register block
  cds_tmr_if.tmr    tif
);

  localparam int UW = $clog2(UNIT_CYCLES + 1);
  localparam logic [UW-1:0] U_LAST = UW'(UNIT_CYCLES - 1);

  logic [UW-1:0] unit_cnt_reg;
  logic          tick;
  logic [8:0]    ms_cnt_reg;
  logic [8:0]    total_p;
  logic [8:0]    total_a;
  cds_tone_e     state_reg;

  assign tick    = (unit_cnt_reg == U_LAST);
  assign total_p = {1'b0, tif.gp} + {1'b0, tif.dp};
  assign total_a = {1'b0, tif.ga} + {1'b0, tif.da};
  assign tif.detect = (state_reg == CDS_TONE_ON);

  // ****************************************************************
  // Millisecond time base
  // ****************************************************************
  // Free running so every window is quantised to the same grid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_cnt_reg <= '0;
    end else if (tick) begin
      unit_cnt_reg <= '0;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + UW'(1);
    end
  end

  // ****************************************************************
  // Qualifier state
  // ****************************************************************
  // Any break in the awaited level restarts the window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg  <= CDS_TONE_OFF;
      ms_cnt_reg <= '0;
    end else if (!tif.enable) begin
      state_reg  <= CDS_TONE_OFF;
      ms_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        CDS_TONE_OFF: begin
          if (!tif.tone_in) begin
            ms_cnt_reg <= '0;
          end else if (tick && (ms_cnt_reg + 9'h001 >= total_p)) begin
            state_reg  <= CDS_TONE_ON;       // [R1]
            ms_cnt_reg <= '0;
          end else if (tick) begin
            ms_cnt_reg <= ms_cnt_reg + 9'h001;
          end
        end
        CDS_TONE_ON: begin
          if (tif.tone_in) begin
            ms_cnt_reg <= '0;
          end else if (tick && (ms_cnt_reg + 9'h001 >= total_a)) begin
            state_reg  <= CDS_TONE_OFF;      // [R2]
            ms_cnt_reg <= '0;
          end else if (tick) begin
            ms_cnt_reg <= ms_cnt_reg + 9'h001;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rec_time;
    @(posedge hclk) disable iff (!hresetn)
      $rose(tif.detect) |-> $past(tif.tone_in) && $past(tick) && ($past(ms_cnt_reg) + 9'h001 >= $past(total_p));
  endproperty
  a_rec_time: assert property (p_rec_time) else $error("Tone detect rose before recognition time"); // [R1]

  property p_abs_time;
    @(posedge hclk) disable iff (!hresetn)
      $fell(tif.detect) && $past(tif.enable) |->
        !$past(tif.tone_in) && $past(tick) && ($past(ms_cnt_reg) + 9'h001 >= $past(total_a));
  endproperty
  a_abs_time: assert property (p_abs_time) else $error("Tone detect fell before absence time"); // [R2]

  property p_break_restarts;
    @(posedge hclk) disable iff (!hresetn)
      tif.enable && !tif.detect && !tif.tone_in |=> ms_cnt_reg == 9'h000;
  endproperty
  a_break_restarts: assert property (p_break_restarts) else $error("Presence window not restarted"); // [R1]

endmodule : cds_tone_timer

// ### hw/cds_receiver.sv
// Caller display receiver control: mode-pin decode, tone qualification,
// shared data-ready / tone-detect pin, carrier flag and AHB-Lite registers.
// Assumes pins synchronous to hclk and a single AHB-Lite master.
//
// Contract
// R1: Tone recognised after present guard plus detect
// R2: Tone dropped after absent guard plus detect
// R3: Host may load line at tone rising edge
// R4: Host removes loads 50-150 ms after carrier ends
// R5: Host may power down when removing loads
// R6: Host leaves FSK mode when none expected
// R7: Power, alert and FSK enables decoded from pins
// R8: Host terminates line 250-400 ms after ring
// R9: Host leaves FSK 50-150 ms after data ends
// R10: Shared pin carries function of current mode
// R11: Host powers down idle, times from carrier edge
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "cds_consts.svh"

module cds_receiver
  import cds_pkg::*;
#(
  parameter int UNIT_CYCLES = `CDS_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Mode-select pins and analog front-end levels
  input  wire logic [2:0]  mode_select_pins,
  input  wire logic        tone_present_in,
  input  wire logic        fsk_carrier_in,
  input  wire logic        byte_ready_n,
  // Decoded controls and device outputs
  output logic             power_down_ctl,
  output logic             line_alert_detect_en,
  output logic             fsk_demod_en,
  output logic             tone_detect_out,
  output logic             carrier_present_n,
  output logic             data_ready_or_tone_pin,
  // Interrupt
  output logic             irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Mode decode, shared by the enables and the carrier gate
  function automatic logic [2:0] mode_dec(input logic [2:0] code);
    logic [2:0] r;
    r = 3'h1;                                  // {fsk, alert, pdn}
    unique case (code)
      CDS_MODE_ALERT:    r = 3'h2;
      CDS_MODE_FSK_BYTE: r = 3'h4;
      CDS_MODE_FSK_BIT:  r = 3'h4;
      default:           r = 3'h1;             // Unused codes power down
    endcase
    return r;
  endfunction : mode_dec

  // Word decode of the low address bits, upper bits must be clear
  function automatic logic hit(input logic [31:0] a, input logic [4:0] off);
    return (a[31:`CDS_ADDR_HI_LSB] == '0) && (a[4:2] == off[4:2]);
  endfunction : hit

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [`CDS_EV_W-1:0] status_reg;
  logic [`CDS_EV_W-1:0] status_next;
  logic [`CDS_EV_W-1:0] mask_reg;
  logic [`CDS_EV_W-1:0] events;
  logic [`CDS_EV_W-1:0] w1c;
  cds_time_t            gp_reg, dp_reg, ga_reg, da_reg;
  logic [2:0]           mode_prev_reg;
  logic                 tone_prev_reg;
  logic                 cd_prev_reg;
  logic                 wr_pend_reg;
  logic [31:0]          wr_addr_reg;
  logic                 acc;
  logic [2:0]           dec;
  logic                 cd_n_next;
  logic [31:0]          rd_next;

  cds_tmr_if tif ();

  // ****************************************************************
  // Tone qualifier
  // ****************************************************************
  assign tif.tone_in = tone_present_in;
  assign tif.enable  = line_alert_detect_en;
  assign tif.gp      = gp_reg;
  assign tif.dp      = dp_reg;
  assign tif.ga      = ga_reg;
  assign tif.da      = da_reg;

  cds_tone_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_tone (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif.tmr)
  );

  // ****************************************************************
  // Mode decode and pin functions
  // ****************************************************************
  assign dec       = mode_dec(mode_select_pins);
  assign cd_n_next = !(dec[2] && fsk_carrier_in);

  // Enables follow the pins one clock later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down_ctl       <= 1'b1;
      line_alert_detect_en <= 1'b0;
      fsk_demod_en         <= 1'b0;
      mode_prev_reg        <= `CDS_CODE_PDN;
    end else begin
      power_down_ctl       <= dec[0];          // [R7]
      line_alert_detect_en <= dec[1];          // [R7]
      fsk_demod_en         <= dec[2];          // [R7]
      mode_prev_reg        <= mode_select_pins;
    end
  end

  // Shared pin: active-low tone detect in alert mode, byte ready in FSK
  // mode, idle high when powered down so no false strobe reaches the host
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ready_or_tone_pin <= 1'b1;
      tone_detect_out        <= 1'b0;
      carrier_present_n      <= 1'b1;
    end else begin
      tone_detect_out   <= tif.detect;
      carrier_present_n <= cd_n_next;       // Gated so a dead demod never shows carrier
      if (line_alert_detect_en) begin
        data_ready_or_tone_pin <= !tif.detect;     // [R10]
      end else if (fsk_demod_en) begin
        data_ready_or_tone_pin <= byte_ready_n;    // [R10]
      end else begin
        data_ready_or_tone_pin <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  // Carrier loss is the host's cue to start its load-removal window
  always_comb begin
    events = '0;
    events[`CDS_EV_TONE_RISE] = tif.detect && !tone_prev_reg;   // [R3]
    events[`CDS_EV_TONE_FALL] = !tif.detect && tone_prev_reg;
    events[`CDS_EV_CARR_GAIN] = !carrier_present_n && cd_prev_reg;
    events[`CDS_EV_CARR_LOSS] = carrier_present_n && !cd_prev_reg; // [R4] [R11]
    events[`CDS_EV_MODE_CHG]  = mode_select_pins != mode_prev_reg;
  end

  assign w1c = (wr_pend_reg && hit(wr_addr_reg, `CDS_OFF_STATUS)) ? hwdata[`CDS_EV_W-1:0] : '0;
  // A new event beats a clear in the same cycle
  assign status_next = (status_reg & ~w1c) | events;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg    <= '0;
      tone_prev_reg <= 1'b0;
      cd_prev_reg   <= 1'b1;
      irq           <= 1'b0;
    end else begin
      status_reg    <= status_next;
      tone_prev_reg <= tif.detect;
      cd_prev_reg   <= carrier_present_n;
      irq           <= |(status_reg & mask_reg);
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; reads are prepared in the address phase
  assign acc = hsel && htrans[1] && hready;

  always_comb begin
    rd_next = 32'h0000_0000;                   // Unmapped reads as zero
    if (hit(haddr, `CDS_OFF_STATUS)) begin
      rd_next[`CDS_EV_W-1:0] = status_reg;
    end else if (hit(haddr, `CDS_OFF_MASK)) begin
      rd_next[`CDS_EV_W-1:0] = mask_reg;
    end else if (hit(haddr, `CDS_OFF_STATE)) begin
      rd_next[5:0] = {carrier_present_n, tif.detect, fsk_demod_en,
                      line_alert_detect_en, power_down_ctl, data_ready_or_tone_pin};
    end else if (hit(haddr, `CDS_OFF_PRES_TIME)) begin
      rd_next[15:0] = {dp_reg, gp_reg};
    end else if (hit(haddr, `CDS_OFF_ABS_TIME)) begin
      rd_next[15:0] = {da_reg, ga_reg};
    end
  end

  // Bus handshake and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= acc && hwrite;
      if (acc) begin
        wr_addr_reg <= haddr;
      end
      if (acc && !hwrite) begin
        hrdata <= rd_next;
      end
    end
  end

  // Writable registers, taken in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= `CDS_MASK_RST;
      gp_reg   <= `CDS_GP_RST;
      dp_reg   <= `CDS_DP_RST;
      ga_reg   <= `CDS_GA_RST;
      da_reg   <= `CDS_DA_RST;
    end else if (wr_pend_reg) begin
      if (hit(wr_addr_reg, `CDS_OFF_MASK)) begin
        mask_reg <= hwdata[`CDS_EV_W-1:0];
      end
      if (hit(wr_addr_reg, `CDS_OFF_PRES_TIME)) begin
        gp_reg <= hwdata[7:0];                 // [R1]
        dp_reg <= hwdata[15:8];
      end
      if (hit(wr_addr_reg, `CDS_OFF_ABS_TIME)) begin
        ga_reg <= hwdata[7:0];                 // [R2]
        da_reg <= hwdata[15:8];
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_one_mode;
    @(posedge hclk) disable iff (!hresetn)
      $onehot({power_down_ctl, line_alert_detect_en, fsk_demod_en});
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("Mode enables not one-hot"); // [R7]

  sequence s_alert_code;
    mode_select_pins == `CDS_CODE_ALERT;
  endsequence
  sequence s_fsk_code;
    mode_select_pins == `CDS_CODE_FSK_BYTE || mode_select_pins == `CDS_CODE_FSK_BIT;
  endsequence

  property p_alert_decode;
    @(posedge hclk) disable iff (!hresetn)
      s_alert_code |=> line_alert_detect_en && !power_down_ctl;
  endproperty
  a_alert_decode: assert property (p_alert_decode) else $error("Alert code not decoded"); // [R7]

  property p_fsk_decode;
    @(posedge hclk) disable iff (!hresetn)
      s_fsk_code |=> fsk_demod_en && !power_down_ctl && !line_alert_detect_en;
  endproperty
  a_fsk_decode: assert property (p_fsk_decode) else $error("FSK code not decoded"); // [R7]

  property p_pin_alert;
    @(posedge hclk) disable iff (!hresetn)
      line_alert_detect_en |=> data_ready_or_tone_pin == !tone_detect_out;
  endproperty
  a_pin_alert: assert property (p_pin_alert) else $error("Shared pin not tone detect"); // [R10]

  property p_pin_fsk;
    @(posedge hclk) disable iff (!hresetn)
      fsk_demod_en |=> data_ready_or_tone_pin == $past(byte_ready_n);
  endproperty
  a_pin_fsk: assert property (p_pin_fsk) else $error("Shared pin not byte ready"); // [R10]

  property p_pin_idle;
    @(posedge hclk) disable iff (!hresetn)
      power_down_ctl |=> data_ready_or_tone_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("Shared pin active in power down"); // [R10]

  property p_tone_flag;
    @(posedge hclk) disable iff (!hresetn)
      $rose(tone_detect_out) |-> status_reg[`CDS_EV_TONE_RISE];
  endproperty
  a_tone_flag: assert property (p_tone_flag) else $error("Tone rise not flagged"); // [R3]

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
      |(status_reg & mask_reg) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised");

endmodule : cds_receiver

// ### tb/cds_host_model.sv
// Host controller model: drives the mode pins and the line load.
// Assumes hclk is shared with the receiver and UNIT is cycles per ms.
`timescale 1ns/1ps

module cds_host_model #(
  parameter int UNIT      = 10,
  parameter int RING_WAIT = 300,
  parameter int END_WAIT  = 100
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench commands
  input  wire logic       arm_alert,
  input  wire logic       ring_end,
  input  wire logic       ovr_en,
  input  wire logic [2:0] ovr_mode,
  // Receiver outputs
  input  wire logic       tone_detect_out,
  input  wire logic       carrier_present_n,
  // Pins and line
  output logic [2:0]      mode_select_pins,
  output logic            line_load
);
  logic [1:0]  st_reg;
  logic [15:0] tmr_reg;
  logic        tone_q;
  logic        car_q;

  // Sequencer: idle, alert, ring wait, FSK
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg    <= 2'h0;
      tmr_reg   <= 16'h0000;
      line_load <= 1'b0;
      tone_q    <= 1'b0;
      car_q     <= 1'b1;
    end else begin
      tone_q <= tone_detect_out;
      car_q  <= carrier_present_n;
      case (st_reg)
        2'h0: begin
          if (arm_alert) st_reg <= 2'h1;
          else if (ring_end) begin
            st_reg  <= 2'h2;
            tmr_reg <= 16'(RING_WAIT * UNIT);
          end
        end
        2'h1: begin
          // Safe only with a 15 ms absent guard
          if (tone_detect_out && !tone_q) begin
            line_load <= 1'b1;
            st_reg    <= 2'h3;
          end
        end
        2'h2: begin
          if (tmr_reg == 16'h0000) begin
            line_load <= 1'b1;
            st_reg    <= 2'h3;
          end else tmr_reg <= tmr_reg - 16'h0001;
        end
        default: begin
          // Timer starts only on the carrier end edge
          if (carrier_present_n && !car_q) tmr_reg <= 16'(END_WAIT * UNIT);
          else if (tmr_reg == 16'h0001) begin
            line_load <= 1'b0;
            st_reg    <= 2'h0;
          end else if (tmr_reg != 16'h0000) tmr_reg <= tmr_reg - 16'h0001;
        end
      endcase
    end
  end

  // Power down outside windows, FSK only while expected
  assign mode_select_pins = ovr_en ? ovr_mode : (st_reg == 2'h1) ? 3'h1 : (st_reg == 2'h3) ? 3'h3 : 3'h0;
endmodule : cds_host_model

// ### tb/caller_display_signalling_sequencer_tb.sv
// Self-checking bench for the receiver with a host model on its pins.
// Assumes the design files compile first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module caller_display_signalling_sequencer_tb;
  import cds_pkg::*;
  localparam int U = 10;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pins, ovr_mode;
  logic        tone, carrier, byte_ready_n, pdn, alert_en, fsk_en, tdo, car_n, pin, load;
  logic        arm, ring, ovr_en, br;
  int          miscompares, checks, seed, n, gp, dp;
  int          rst_q[$] = '{0, 0, 'h23, 'h0a0a, 'h0a0f, 0};

  // ****************************************************************
  // Design and host
  // ****************************************************************
  cds_receiver #(.UNIT_CYCLES(U)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mode_select_pins(pins), .tone_present_in(tone), .fsk_carrier_in(carrier), .byte_ready_n(byte_ready_n),
    .power_down_ctl(pdn), .line_alert_detect_en(alert_en), .fsk_demod_en(fsk_en), .tone_detect_out(tdo),
    .carrier_present_n(car_n), .data_ready_or_tone_pin(pin), .irq(irq));
  cds_host_model #(.UNIT(U)) i_host (
    .hclk(hclk), .hresetn(hresetn), .arm_alert(arm), .ring_end(ring), .ovr_en(ovr_en), .ovr_mode(ovr_mode),
    .tone_detect_out(tdo), .carrier_present_n(car_n), .mode_select_pins(pins), .line_load(load));

  // 40 MHz clock
  always #12.5 hclk = ~hclk;

  // Verdict, also reached by any timeout
  task automatic results();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // One AHB-Lite single transfer, bounded waits on hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
    if (k >= 50) begin miscompares++; results(); end
  endtask : bus

  // Count edges until tone detect (sel 0) or line load reaches v
  task automatic wait_until(input int sel, input logic v, input int lim, output int m);
    m = 0;
    while (m < lim && ((sel == 0) ? tdo : load) !== v) begin @(posedge hclk); m++; end
    if (m >= lim) begin miscompares++; $display("[ERR] wait %0d timed out", sel); results(); end
  endtask : wait_until

  // Hang guard
  initial begin
    repeat (100000) @(posedge hclk);
    miscompares++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    tone = 0; carrier = 0; byte_ready_n = 1; arm = 0; ring = 0; ovr_en = 0; ovr_mode = 0;
    seed = 32'h017f_9947; miscompares = 0; checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_q[i]) begin bus(0, i * 4, 0, rd); `CHK("reset_reg", rst_q[i], rd) end
    bus(1, 32'h0000_0014, 32'hffff_ffff, rd); bus(0, 32'h0000_0014, 0, rd); `CHK("unmapped", 0, rd)
    bus(1, 32'h0000_0008, 0, rd); bus(0, 32'h0000_0008, 0, rd); `CHK("state_ro", 'h23, rd)
    bus(1, 32'h0000_0004, 32'h0000_001f, rd); bus(0, 32'h0000_0004, 0, rd); `CHK("mask", 'h1f, rd)
    // Every mode code, random byte-ready level on the shared pin
    ovr_en <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      ovr_mode <= c[2:0]; br = 1'($random(seed)); byte_ready_n <= br;
      repeat (4) @(posedge hclk);
      `CHK("pdn", !(c >= 1 && c <= 3), pdn)
      `CHK("alert_en", (c == 1), alert_en)
      `CHK("fsk_en", (c == 2 || c == 3), fsk_en)
      `CHK("shared_pin", (c == 2 || c == 3) ? br : 1'b1, pin)
    end
    `CHK("irq_set", 1'b1, irq)
    bus(1, 0, 32'h0000_001f, rd); repeat (2) @(posedge hclk); `CHK("irq_clr", 1'b0, irq)
    // Random present window, short absent window
    gp = ($random(seed) & 3) + 1; dp = ($random(seed) & 3) + 1;
    bus(1, 32'h0000_000c, (dp << 8) | gp, rd); bus(1, 32'h0000_0010, 32'h0000_0102, rd);
    ovr_mode <= 3'h1; repeat (4) @(posedge hclk);
    tone <= 1'b1; repeat ((gp + dp - 1) * U - 2) @(posedge hclk);
    tone <= 1'b0; repeat (2 * U) @(posedge hclk); `CHK("glitch", 1'b0, tdo)
    bus(1, 0, 32'h0000_001f, rd); bus(1, 4, 32'h0000_0001, rd);
    tone <= 1'b1; wait_until(0, 1, 1000, n);
    `CHK("rec_time", 1'b1, (n >= (gp + dp - 1) * U && n <= (gp + dp) * U + 4))
    repeat (2) @(posedge hclk); `CHK("pin_tone", 1'b0, pin)
    `CHK("irq_tone", 1'b1, irq)
    bus(1, 0, 32'h0000_0001, rd); repeat (2) @(posedge hclk); `CHK("irq_w1c", 1'b0, irq)
    tone <= 1'b0; wait_until(0, 0, 1000, n);
    `CHK("abs_time", 1'b1, (n >= 2 * U && n <= 3 * U + 4))
    repeat (2) @(posedge hclk); `CHK("irq_masked", 1'b0, irq)
    bus(0, 0, 0, rd); `CHK("fall_evt", 32'h2, rd & 32'h2)
    ovr_mode <= 3'h0; tone <= 1'b1; repeat (10 * U) @(posedge hclk); `CHK("tone_off", 1'b0, tdo)
    // Host sequence led by the tone alert
    tone <= 1'b0; bus(1, 32'h0000_0010, 32'h0000_0a0f, rd);
    ovr_en <= 1'b0; arm <= 1'b1; @(posedge hclk); arm <= 1'b0;
    tone <= 1'b1; wait_until(0, 1, 1000, n); wait_until(1, 1, 4, n);
    repeat (3) @(posedge hclk); `CHK("fsk_sel", 1'b1, fsk_en)
    tone <= 1'b0; carrier <= 1'b1; repeat (5) @(posedge hclk); `CHK("carrier", 1'b0, car_n)
    carrier <= 1'b0; wait_until(1, 0, 2000, n);
    `CHK("end_time", 1'b1, (n >= 50 * U && n <= 150 * U))
    repeat (2) @(posedge hclk); `CHK("pdn_end", 1'b1, pdn)
    bus(0, 0, 0, rd); `CHK("carr_loss", 32'h8, rd & 32'h8)
    // Host sequence led by the ring burst
    ring <= 1'b1; @(posedge hclk); ring <= 1'b0; wait_until(1, 1, 5000, n);
    `CHK("ring_time", 1'b1, (n >= 250 * U && n <= 400 * U))
    results();
  end
endmodule : caller_display_signalling_sequencer_tb
